// ===== core/uat_tx_core.sv
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module uat_tx_core (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    output logic            tx_out,
    output logic            tx_pin_owned,
    output logic            rx_pin_owned,
    output logic            tx_empty_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Build the shifted word with ninth bit and parity in place
    function automatic logic [8:0] frame_word(
        input logic [7:0] data,
        input logic       nine,
        input logic       par_en,
        input logic       odd,
        input logic       ninth
    );
        logic [8:0] w;
        w = {ninth & nine, data};
        if (par_en) begin
            if (nine) begin
                w[8] = (^data) ^ odd;
            end else begin
                w[7] = (^data[6:0]) ^ odd;
            end
        end
        return w;
    endfunction

    // Last prescale count for the selected speed
    function automatic logic [5:0] pre_max(input logic high);
        return high ? uat_pkg::PRE_HIGH_MAX : uat_pkg::PRE_LOW_MAX;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    uat_pkg::uat_state_t s_r;
    uat_pkg::uat_state_t s_nxt;

    logic tick;
    logic tx_run;
    logic uen_nxt;
    logic idle_set;
    logic [3:0] last_bit;
    logic [7:0] status;

    // Baud tick when both prescaler and divisor reach their ends
    assign tick = (s_r.pre == pre_max(s_r.ctrl2[uat_pkg::C2_HIGH]))
                && (s_r.div == s_r.baud);

    assign tx_run = s_r.ctrl1[uat_pkg::C1_UNIT_EN]
                  & s_r.ctrl2[uat_pkg::C2_TX_EN];

    assign last_bit = s_r.ctrl1[uat_pkg::C1_NINE] ? uat_pkg::LAST_BIT_9
                                                    : uat_pkg::LAST_BIT_8;

    // Status word; receive side flags rest in their idle values
    always_comb begin
        status = 8'h00;
        status[uat_pkg::ST_RX_IDLE]  = 1'b1;
        status[uat_pkg::ST_TX_IDLE]  = s_r.idle;
        status[uat_pkg::ST_TX_EMPTY] = s_r.empty;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        uen_nxt = 1'b0;
        idle_set = 1'b0;

        // Free running baud generator
        if (tick) begin
            s_nxt.pre = 6'h00;
            s_nxt.div = 8'h00;
        end else if (s_r.pre == pre_max(s_r.ctrl2[uat_pkg::C2_HIGH])) begin
            s_nxt.pre = 6'h00;
            s_nxt.div = s_r.div + 8'h01;
        end else begin
            s_nxt.pre = s_r.pre + 6'h01;
        end

        // Transmit sequencer
        unique case (s_r.state)
            uat_pkg::TX_IDLE: begin
                s_nxt.txd = 1'b1;
                if (tx_run && s_r.pending) begin
                    s_nxt.shifter = frame_word(s_r.buf_d,
                        s_r.ctrl1[uat_pkg::C1_NINE],
                        s_r.ctrl1[uat_pkg::C1_PAR_EN],
                        s_r.ctrl1[uat_pkg::C1_PAR_ODD],
                        s_r.ctrl1[uat_pkg::C1_TX_NINTH]);
                    s_nxt.pending = 1'b0;
                    s_nxt.empty = 1'b1;
                    s_nxt.state = uat_pkg::TX_START;
                    s_nxt.bit_cnt = 4'h0;
                    s_nxt.pre = 6'h00;
                    s_nxt.div = 8'h00;
                    s_nxt.txd = 1'b0;
                end
            end
            uat_pkg::TX_START: begin
                if (tick) begin
                    s_nxt.state = uat_pkg::TX_DATA;
                    s_nxt.txd = s_r.shifter[0];
                end
            end
            uat_pkg::TX_DATA: begin
                if (tick) begin
                    if (s_r.bit_cnt == last_bit) begin
                        s_nxt.state = uat_pkg::TX_STOP;
                        s_nxt.stop_cnt = 1'b0;
                        s_nxt.txd = 1'b1;
                    end else begin
                        s_nxt.shifter = {1'b1, s_r.shifter[8:1]};
                        s_nxt.txd = s_r.shifter[1];
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    end
                end
            end
            uat_pkg::TX_STOP: begin
                s_nxt.txd = 1'b1;
                if (tick) begin
                    if (s_r.ctrl1[uat_pkg::C1_TWO_STOP]
                        && !s_r.stop_cnt) begin
                        s_nxt.stop_cnt = 1'b1;
                    end else begin
                        s_nxt.state = uat_pkg::TX_IDLE;
                        s_nxt.idle = 1'b1;
                        idle_set = 1'b1;
                    end
                end
            end
        endcase

        // Register reads, data one cycle later
        if (rd) begin
            unique case (addr)
                uat_pkg::OFS_CTRL_ONE: begin
                    s_nxt.rdata = s_r.ctrl1;
                    s_nxt.rdata[uat_pkg::C1_TX_NINTH] = 1'b0;
                    s_nxt.rdata[uat_pkg::C1_RX_NINTH] = 1'b0;
                end
                uat_pkg::OFS_CTRL_TWO: begin
                    s_nxt.rdata = s_r.ctrl2;
                end
                uat_pkg::OFS_STATUS: begin
                    s_nxt.rdata = status;
                    s_nxt.seen = 1'b1;
                end
                uat_pkg::OFS_BAUD: begin
                    s_nxt.rdata = s_r.baud;
                end
                default: begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Register writes
        if (wr) begin
            unique case (addr)
                uat_pkg::OFS_CTRL_ONE: begin
                    s_nxt.ctrl1 = wdata;
                    s_nxt.ctrl1[uat_pkg::C1_RX_NINTH] = 1'b0;
                end
                uat_pkg::OFS_CTRL_TWO: begin
                    s_nxt.ctrl2 = wdata;
                end
                uat_pkg::OFS_BAUD: begin
                    s_nxt.baud = wdata;
                end
                uat_pkg::OFS_STATUS: begin
                    s_nxt.seen = 1'b1;
                end
                uat_pkg::OFS_DATA: begin
                    if (s_r.empty) begin
                        if (s_r.seen) begin
                            s_nxt.empty = 1'b0;
                            s_nxt.idle = 1'b0;
                        end
                        s_nxt.seen = 1'b0;
                        if (tx_run && s_r.state == uat_pkg::TX_IDLE
                            && !s_r.pending) begin
                            // Straight into the shifter
                            s_nxt.shifter = frame_word(wdata,
                                s_r.ctrl1[uat_pkg::C1_NINE],
                                s_r.ctrl1[uat_pkg::C1_PAR_EN],
                                s_r.ctrl1[uat_pkg::C1_PAR_ODD],
                                s_r.ctrl1[uat_pkg::C1_TX_NINTH]);
                            s_nxt.empty = 1'b1;
                            s_nxt.state = uat_pkg::TX_START;
                            s_nxt.bit_cnt = 4'h0;
                            s_nxt.pre = 6'h00;
                            s_nxt.div = 8'h00;
                            s_nxt.txd = 1'b0;
                        end else begin
                            s_nxt.buf_d = wdata;
                            s_nxt.pending = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Frame end beats a same-cycle clearing write
        if (idle_set) begin
            s_nxt.idle = 1'b1;
        end

        // Unit disable: abort, empty buffer, reset transmit and receive enables and flags
        uen_nxt = s_nxt.ctrl1[uat_pkg::C1_UNIT_EN];
        if (!uen_nxt) begin
            s_nxt.ctrl2[uat_pkg::C2_TX_EN] = 1'b0;
            s_nxt.ctrl2[uat_pkg::C2_RX_EN] = 1'b0;
            s_nxt.ctrl1[uat_pkg::C1_BREAK] = 1'b0;
        end
        // Abort on unit disable or a falling transmit enable, not a low one, so a byte may wait
        if (!uen_nxt || (s_r.ctrl2[uat_pkg::C2_TX_EN]
                         && !s_nxt.ctrl2[uat_pkg::C2_TX_EN])) begin
            s_nxt.pending = 1'b0;
            s_nxt.state = uat_pkg::TX_IDLE;
            s_nxt.empty = 1'b1;
            s_nxt.idle = 1'b1;
            s_nxt.txd = 1'b1;
        end
    end

    // Single state register, power-on defaults give 8 N 1
    always_ff @(posedge clock) begin
        if (srst) begin
            s_r <= uat_pkg::UAT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata = s_r.rdata;
    assign tx_out = s_r.txd;
    // Pin ownership follows the enables
    assign tx_pin_owned = tx_run;
    assign rx_pin_owned = s_r.ctrl1[uat_pkg::C1_UNIT_EN]
                        & s_r.ctrl2[uat_pkg::C2_RX_EN];
    assign tx_empty_irq = s_r.empty
                        & s_r.ctrl2[uat_pkg::C2_TE_IE];

endmodule

// ===== inc/uat_pkg.sv
package uat_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] OFS_CTRL_ONE = 3'h0;
    localparam logic [2:0] OFS_CTRL_TWO = 3'h1;
    localparam logic [2:0] OFS_STATUS   = 3'h2;
    localparam logic [2:0] OFS_DATA     = 3'h3;
    localparam logic [2:0] OFS_BAUD     = 3'h4;

    // Field positions in control_reg_one
    localparam int C1_UNIT_EN  = 7;
    localparam int C1_NINE     = 6;
    localparam int C1_PAR_EN   = 5;
    localparam int C1_PAR_ODD  = 4;
    localparam int C1_TWO_STOP = 3;
    localparam int C1_BREAK    = 2;
    localparam int C1_RX_NINTH = 1;
    localparam int C1_TX_NINTH = 0;

    // Field positions in control_reg_two
    localparam int C2_TX_EN  = 7;
    localparam int C2_RX_EN  = 6;
    localparam int C2_HIGH   = 5;
    localparam int C2_TE_IE  = 0;

    // Field positions in serial_status_reg
    localparam int ST_RX_IDLE  = 3;
    localparam int ST_TX_IDLE  = 1;
    localparam int ST_TX_EMPTY = 0;

    // Reset values
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] BAUD_RST     = 8'h00;

    // Baud prescale factors and their last counts
    localparam int         PRE_LOW      = 64;
    localparam int         PRE_HIGH     = 16;
    localparam logic [5:0] PRE_LOW_MAX  = 6'(PRE_LOW - 1);
    localparam logic [5:0] PRE_HIGH_MAX = 6'(PRE_HIGH - 1);

    // Index of last data position for 8 and 9 bit words
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;

    // Transmitter states, Gray coded along the frame
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b11,
        TX_STOP  = 2'b10
    } uat_tx_state_t;

    // Whole state of the transmit core
    typedef struct packed {
        logic [7:0]    ctrl1;
        logic [7:0]    ctrl2;
        logic [7:0]    baud;
        logic          empty;
        logic          idle;
        logic          pending;
        logic          seen;
        logic [7:0]    buf_d;
        logic [8:0]    shifter;
        uat_tx_state_t state;
        logic [3:0]    bit_cnt;
        logic          stop_cnt;
        logic [5:0]    pre;
        logic [7:0]    div;
        logic          txd;
        logic [7:0]    rdata;
    } uat_state_t;

    localparam uat_state_t UAT_RST = '{
        ctrl1:    CTRL_ONE_RST,
        ctrl2:    CTRL_TWO_RST,
        baud:     BAUD_RST,
        empty:    1'b1,
        idle:     1'b1,
        pending:  1'b0,
        seen:     1'b0,
        buf_d:    8'h00,
        shifter:  9'h1ff,
        state:    TX_IDLE,
        bit_cnt:  4'h0,
        stop_cnt: 1'b0,
        pre:      6'h00,
        div:      8'h00,
        txd:      1'b1,
        rdata:    8'h00
    };

endpackage

// ===== tb/uat_rx_model.sv
`timescale 1ns/10ps
// Remote receiver, samples each bit in its middle
module uat_rx_model (
    input  wire logic        clock,
    input  wire logic        line,
    input  wire logic [3:0]  nbits,
    input  wire logic [15:0] bit_len,
    output logic      [8:0]  word,
    output logic      [7:0]  frame_cnt,
    output logic             stop_ok
);
    // Start edge, data LSB first, then one stop bit only
    initial begin
        word = 9'h000;
        frame_cnt = 8'h00;
        stop_ok = 1'b0;
        forever begin
            @(negedge line);
            repeat (bit_len / 2) @(posedge clock);
            word = 9'h000;
            for (int i = 0; i < nbits; i++) begin
                repeat (bit_len) @(posedge clock);
                word[i] = line;
            end
            repeat (bit_len) @(posedge clock);
            stop_ok = line;
            frame_cnt = frame_cnt + 8'h01;
        end
    end
endmodule

// ===== tb/uat_tx_core_assertions.sv
`timescale 1ns/10ps
// Port checks of the transmit core
module uat_tx_chk (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       tx_out,
    input wire logic       tx_pin_owned,
    input wire logic       rx_pin_owned,
    input wire logic       tx_empty_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    // Reset, enables and interrupt
    property p_reset_pins;
        $fell(srst) |-> tx_out && !tx_pin_owned && !tx_empty_irq;
    endproperty
    a_reset_pins: assert property (p_reset_pins)
        else $error("line or pins wrong after reset");
    property p_unit_off;
        wr && addr == uat_pkg::OFS_CTRL_ONE && !wdata[uat_pkg::C1_UNIT_EN]
            |=> !tx_pin_owned && !rx_pin_owned;
    endproperty
    a_unit_off: assert property (p_unit_off)
        else $error("pins kept after unit disable");
    property p_transmit_enable_off;
        wr && addr == uat_pkg::OFS_CTRL_TWO && !wdata[uat_pkg::C2_TX_EN]
            |=> !tx_pin_owned ##1 tx_out;
    endproperty
    a_transmit_enable_off: assert property (p_transmit_enable_off)
        else $error("frame not stopped by transmit disable");
    property p_irq_off;
        wr && addr == uat_pkg::OFS_CTRL_TWO && !wdata[uat_pkg::C2_TE_IE]
            |=> !tx_empty_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt while masked");
    // Line timing and ownership
    property p_start_len; $fell(tx_out) |-> !tx_out [*8]; endproperty
    a_start_len: assert property (p_start_len)
        else $error("low bit shorter than a bit time");
    property p_high_len;
        $rose(tx_out) && tx_pin_owned |-> tx_out [*8];
    endproperty
    a_high_len: assert property (p_high_len)
        else $error("high bit shorter than a bit time");
    property p_idle_high; !tx_pin_owned |=> tx_out; endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("line low while not owned");
    property p_start_owned; $fell(tx_out) |-> tx_pin_owned; endproperty
    a_start_owned: assert property (p_start_owned)
        else $error("frame started while disabled");
    c_frame: cover property ($fell(tx_out));
    c_abort: cover property ($fell(tx_pin_owned) && $rose(tx_out));
    c_irq: cover property ($rose(tx_empty_irq));
endmodule

bind uat_tx_core uat_tx_chk u_chk (
    .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tx_out(tx_out), .tx_pin_owned(tx_pin_owned),
    .rx_pin_owned(rx_pin_owned), .tx_empty_irq(tx_empty_irq)
);

// ===== tb/uat_tx_core_test.sv
`timescale 1ns/10ps
// Bench for the transmit core
module uat_tx_core_test;
    localparam logic [7:0] UEN = 8'h01 << uat_pkg::C1_UNIT_EN;
    localparam logic [7:0] TXE = 8'h01 << uat_pkg::C2_TX_EN;
    localparam logic [7:0] RXE = 8'h01 << uat_pkg::C2_RX_EN;
    localparam logic [7:0] HSP = 8'h01 << uat_pkg::C2_HIGH;
    localparam logic [7:0] RXI = 8'h01 << uat_pkg::ST_RX_IDLE;
    localparam logic [7:0] TEM = 8'h01 << uat_pkg::ST_TX_EMPTY;
    localparam logic [7:0] ALL = RXI | TEM | 8'h01 << uat_pkg::ST_TX_IDLE;
    localparam logic [2:0] C1  = uat_pkg::OFS_CTRL_ONE;
    localparam logic [2:0] C2  = uat_pkg::OFS_CTRL_TWO;
    localparam logic [2:0] STA = uat_pkg::OFS_STATUS;
    localparam logic [2:0] DAT = uat_pkg::OFS_DATA;
    localparam logic [2:0] BRD = uat_pkg::OFS_BAUD;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic        tx_out;
    logic        tx_pin_owned;
    logic        rx_pin_owned;
    logic        tx_empty_irq;
    logic [3:0]  nbits = 4'h8;
    logic [15:0] bit_len = 16'h0010;
    logic [8:0]  word;
    logic [7:0]  frame_cnt;
    logic        stop_ok;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          frames = 0;
    uat_tx_core DUT (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .tx_out(tx_out),
        .tx_pin_owned(tx_pin_owned), .rx_pin_owned(rx_pin_owned),
        .tx_empty_irq(tx_empty_irq));
    uat_rx_model u_far (.clock(clock), .line(tx_out), .nbits(nbits),
        .bit_len(bit_len), .word(word), .frame_cnt(frame_cnt),
        .stop_ok(stop_ok));
    // Clock
    initial begin
        forever #50 clock = ~clock;
    end
    ////////////////////////////////////////
    // Helpers
    task results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [8:0] e, input logic [8:0] g);
        num_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check(nm, {1'b0, e}, {1'b0, rdata});
    endtask
    // Unit enable first: transmit and receive enables are held clear while it is off
    task cfg(input logic [7:0] n, input logic hs);
        wr_reg(BRD, n);
        wr_reg(C1, UEN);
        wr_reg(C2, TXE | RXE | (hs ? HSP : 8'h00));
        bit_len = 16'((n + 1)
            * (hs ? uat_pkg::PRE_HIGH : uat_pkg::PRE_LOW));
    endtask
    task wait_frame(input logic [8:0] e);
        frames++;
        for (int i = 0; i < 40000 && frame_cnt != frames; i++)
            @(posedge clock);
        if (frame_cnt != frames) begin
            $display("ERROR frames expected %0d seen %0d", frames, frame_cnt);
            error_cnt++;
            results();
        end
        check("word", e, word);
        check("stop", 9'h001, {8'h00, stop_ok});
    endtask
    task automatic frame_case(input logic [7:0] c1, input logic [7:0] d);
        int n;
        logic [8:0] e;
        n = c1[uat_pkg::C1_NINE] ? 9 : 8;
        e = {c1[uat_pkg::C1_TX_NINTH] & c1[uat_pkg::C1_NINE], d};
        if (c1[uat_pkg::C1_PAR_EN]) begin
            e[n-1] = 1'b0;
            e[n-1] = c1[uat_pkg::C1_PAR_ODD] ^ (^e);
        end
        nbits = 4'(n);
        wr_reg(C1, UEN | c1);
        rd_chk(STA, ALL, "status idle");
        wr_reg(DAT, d);
        rd_chk(STA, RXI | TEM, "status direct");
        wait_frame(e);
        repeat (bit_len * 2 + 4) @(posedge clock);
        rd_chk(STA, ALL, "status done");
    endtask
    ////////////////////////////////////////
    // Scenarios
    task t_reset;
        check("line", 9'h001, {8'h00, tx_out});
        rd_chk(STA, ALL, "status");
        rd_chk(C1, 8'h00, "ctrl one");
        wr_reg(3'h5, 8'hff);
        rd_chk(3'h5, 8'h00, "unmapped");
        wr_reg(C2, 8'h01 << uat_pkg::C2_TE_IE);
        rd_chk(BRD, 8'h00, "baud");
        check("irq", 9'h001, {8'h00, tx_empty_irq});
        wr_reg(C2, 8'h00);
        rd_chk(C2, 8'h00, "ctrl two");
        check("irq", 9'h000, {8'h00, tx_empty_irq});
        $display("t_reset done");
    endtask
    task t_formats;
        logic [7:0] fmt [6] = '{8'h00, 8'h20, 8'h30, 8'h49, 8'h70, 8'h68};
        check("rx owner", 9'h000, {8'h00, rx_pin_owned});
        cfg(8'h00, 1'b1);
        for (int i = 0; i < 6; i++)
            frame_case(fmt[i], 8'h96 ^ 8'(i));
        check("rx owner", 9'h001, {8'h00, rx_pin_owned});
        $display("t_formats done");
    endtask
    task t_queue;
        nbits = 4'h8;
        wr_reg(C1, UEN);
        rd_chk(STA, ALL, "status idle");
        wr_reg(DAT, 8'h3c);
        rd_chk(STA, RXI | TEM, "status direct");
        wr_reg(DAT, 8'hc3);
        rd_chk(STA, RXI, "status full");
        wr_reg(DAT, 8'h0f);
        wait_frame(9'h03c);
        wait_frame(9'h0c3);
        repeat (bit_len * 12) @(posedge clock);
        check("frames", 9'(frames), {1'b0, frame_cnt});
        rd_chk(STA, ALL, "status done");
        $display("t_queue done");
    endtask
    task t_bit_time;
        int cnt;
        for (int k = 0; k < 2; k++) begin
            cfg(k ? 8'h02 : 8'h01, k[0]);
            rd_chk(STA, ALL, "status idle");
            wr_reg(DAT, 8'h01);
            cnt = 0;
            for (int i = 0; i < 2000 && !(cnt > 0 && tx_out); i++) begin
                @(posedge clock);
                if (tx_out === 1'b0) cnt++;
            end
            check("bit time", 9'(bit_len), 9'(cnt));
            wait_frame(9'h001);
            repeat (bit_len * 2 + 4) @(posedge clock);
        end
        $display("t_bit_time done");
    endtask
    task t_abort;
        cfg(8'h01, 1'b1);
        wr_reg(C1, UEN | 8'h28);
        rd_chk(STA, ALL, "status idle");
        wr_reg(DAT, 8'h00);
        repeat (40) @(posedge clock);
        wr_reg(C2, RXE | HSP);
        rd_chk(STA, ALL, "status abort");
        check("line", 9'h001, {8'h00, tx_out});
        check("tx owner", 9'h000, {8'h00, tx_pin_owned});
        wr_reg(C1, 8'h28);
        rd_chk(C2, HSP, "ctrl two");
        check("rx owner", 9'h000, {8'h00, rx_pin_owned});
        rd_chk(C1, 8'h28, "ctrl one");
        rd_chk(BRD, 8'h01, "baud");
        repeat (bit_len * 12) @(posedge clock);
        frames = frame_cnt;
        wr_reg(C1, UEN | 8'h28);
        rd_chk(STA, ALL, "status enabled");
        wr_reg(DAT, 8'h81);
        rd_chk(STA, RXI, "status held");
        wr_reg(C2, TXE | RXE | HSP);
        wait_frame(9'h081);
        repeat (bit_len * 3) @(posedge clock);
        frame_case(8'h28, 8'h81);
        $display("t_abort done");
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_formats();
        t_queue();
        t_bit_time();
        t_abort();
        results();
    end
endmodule
